// ==== rtl/sbs_pkg.sv ====
// sbs_pkg: constants, state encodings and helper functions for the link self-test block.
// assumes one 100 MHz clock domain shared by the transmit and receive flag interfaces.
package sbs_pkg;

    localparam int CHAR_W = 8;
    localparam int LFSR_W = 9;
    // state that makes the encoder emit the loop-start data character (all zero)
    localparam logic [LFSR_W-1:0] LFSR_SEED = 9'h100;
    localparam logic [CHAR_W-1:0] LOOP_START_CHAR = 8'h00;
    // feedback taps for x^9 + x^5 + 1, a 511-state maximal sequence
    localparam int TAP_HI = 8;
    localparam int TAP_LO = 4;

    localparam int ERR_WIN = 28;
    localparam int ERR_CNT_W = 5;
    localparam logic [ERR_CNT_W-1:0] ERR_LIMIT = 5'h0e;

    // reset value of a synchronised active-low enable: inactive
    localparam logic ENABLE_N_RST = 1'b1;
    // output enables are active low; high means the pin floats
    localparam logic OE_OFF = 1'b1;
    // timing model select: 1 = flags active high, 0 = flags active low
    localparam logic MODEL_HIGH = 1'b1;

    typedef enum logic [0:0] {
        SBS_TX_NORMAL = 1'b0,
        SBS_TX_BIST = 1'b1
    } sbs_tx_state_t;

    typedef enum logic [1:0] {
        SBS_RX_NORMAL = 2'b00,
        SBS_RX_HUNT = 2'b01,
        SBS_RX_SYNC = 2'b10
    } sbs_rx_state_t;

    function automatic logic [LFSR_W-1:0] lfsr_next(input logic [LFSR_W-1:0] s);
        return {s[LFSR_W-2:0], s[TAP_HI] ^ s[TAP_LO]};
    endfunction

    // logical flag state to pin level under the selected timing model
    function automatic logic flag_pin(input logic act, input logic model);
        return (model == MODEL_HIGH) ? act : ~act;
    endfunction

    function automatic logic err_over_limit(input logic [ERR_WIN-1:0] h);
        logic [ERR_CNT_W-1:0] n;
        n = '0;
        for (int i = 0; i < ERR_WIN; i++) begin
            n = n + ERR_CNT_W'(h[i]);
        end
        return n >= ERR_LIMIT;
    endfunction

endpackage

// ==== rtl/sbs_sync2.sv ====
// sbs_sync2: two-stage synchroniser for an asynchronous active-low enable.
// assumes the input may change at any time relative to clk.
`timescale 1ns/10ps
module sbs_sync2 (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic async_in,
    output logic sync_out
);

    typedef struct packed {
        logic meta;
        logic sync;
    } sbs_sync_st_t;

    sbs_sync_st_t s_q;
    sbs_sync_st_t s_d;

    always_comb begin
        s_d.meta = async_in;
        // only the second stage reads the first
        s_d.sync = s_q.meta;
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s_q <= {sbs_pkg::ENABLE_N_RST, sbs_pkg::ENABLE_N_RST};
        end else begin
            s_q <= s_d;
        end
    end

    assign sync_out = s_q.sync;

endmodule

// ==== rtl/sbs_lfsr.sv ====
// sbs_lfsr: 9-bit pattern register shared by generator and checker.
// assumes load has priority over step.
`timescale 1ns/10ps
module sbs_lfsr (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic load,
    input wire logic [sbs_pkg::LFSR_W-1:0] load_val,
    input wire logic step,
    output logic [sbs_pkg::LFSR_W-1:0] state_q
);

    logic [sbs_pkg::LFSR_W-1:0] state_d;

    always_comb begin
        state_d = state_q;
        if (load) begin
            state_d = load_val;
        end else if (step) begin
            state_d = sbs_pkg::lfsr_next(state_q);
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_q <= sbs_pkg::LFSR_SEED;
        end else begin
            state_q <= state_d;
        end
    end

endmodule

// ==== rtl/sbs_bist_top.sv ====
// sbs_bist_top: link self-test generator, checker and flag reporting for a serial transceiver.
// assumes the fifos, encoder and decoder sit outside; one character per clk on both paths.
//
`timescale 1ns/10ps
module sbs_bist_top (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic tx_selftest_enable_n,
    input wire logic rx_selftest_enable_n,
    input wire logic addr_match_n,
    input wire logic rx_select_n,
    input wire logic timing_model_select,
    input wire logic fifo_bypass_n,
    input wire logic tx_fifo_avail,
    input wire logic [sbs_pkg::CHAR_W-1:0] tx_fifo_data,
    input wire logic tx_pair_pending,
    input wire logic tx_fifo_empty_in,
    input wire logic tx_fifo_full_in,
    input wire logic [sbs_pkg::CHAR_W-1:0] rx_char,
    input wire logic rx_char_valid,
    input wire logic rx_atomic_pending,
    input wire logic rx_addr_cmd_valid,
    input wire logic rx_addr_hit,
    input wire logic multicast_all_ones,
    input wire logic rx_fifo_wr_req,
    input wire logic rx_fifo_rd_req,
    input wire logic rx_fifo_empty_in,
    input wire logic rx_fifo_half_in,
    input wire logic rx_fifo_full_in,
    output logic tx_fifo_rd_en,
    output logic [sbs_pkg::CHAR_W-1:0] tx_char,
    output logic tx_char_valid,
    output logic tx_fifo_empty_flag,
    output logic tx_fifo_full_flag,
    output logic tx_flags_oe_n,
    output logic rx_fifo_wr_en,
    output logic rx_fifo_rd_en,
    output logic rx_fifo_empty_flag,
    output logic rx_fifo_half_flag,
    output logic rx_fifo_full_flag,
    output logic rx_flags_oe_n,
    output logic rx_error_bit,
    output logic rx_bus_oe_n
);

    ////////////////////////////////////////////////////////////////////////////////
    // state

    typedef struct packed {
        sbs_pkg::sbs_tx_state_t tx_st;
        sbs_pkg::sbs_rx_state_t rx_st;
        logic tx_rd;
        logic [sbs_pkg::CHAR_W-1:0] tx_char;
        logic tx_valid;
        logic tx_empty_hold;
        logic tx_empty_pin;
        logic tx_full_pin;
        logic tx_oe_n;
        logic [sbs_pkg::ERR_WIN-1:0] err_hist;
        logic rx_full_hold;
        logic err_hold;
        logic match;
        logic drop;
        logic rx_wr;
        logic rx_rd;
        logic rx_empty_pin;
        logic rx_half_pin;
        logic rx_full_pin;
        logic rx_oe_n;
        logic err_pin;
        logic bus_oe_n;
    } sbs_st_t;

    localparam sbs_st_t ST_RST = '{
        tx_st: sbs_pkg::SBS_TX_NORMAL,
        rx_st: sbs_pkg::SBS_RX_NORMAL,
        tx_rd: 1'b0,
        tx_char: '0,
        tx_valid: 1'b0,
        tx_empty_hold: 1'b0,
        tx_empty_pin: 1'b0,
        tx_full_pin: 1'b0,
        tx_oe_n: sbs_pkg::OE_OFF,
        err_hist: '0,
        rx_full_hold: 1'b0,
        err_hold: 1'b0,
        match: 1'b0,
        drop: 1'b0,
        rx_wr: 1'b0,
        rx_rd: 1'b0,
        rx_empty_pin: 1'b0,
        rx_half_pin: 1'b0,
        rx_full_pin: 1'b0,
        rx_oe_n: sbs_pkg::OE_OFF,
        err_pin: 1'b0,
        bus_oe_n: sbs_pkg::OE_OFF
    };

    sbs_st_t q;
    sbs_st_t d;

    logic tx_en_sync_n;
    logic rx_en_sync_n;
    logic tx_bist;
    logic rx_bist;
    logic [sbs_pkg::LFSR_W-1:0] tx_lfsr;
    logic [sbs_pkg::LFSR_W-1:0] rx_lfsr;
    logic rx_load;
    logic rx_step;

    ////////////////////////////////////////////////////////////////////////////////
    // enable synchronisers and pattern registers

    sbs_sync2 u_tx_sync (
        .clk(clk),
        .rst_n(rst_n),
        .async_in(tx_selftest_enable_n),
        .sync_out(tx_en_sync_n)
    );

    sbs_sync2 u_rx_sync (
        .clk(clk),
        .rst_n(rst_n),
        .async_in(rx_selftest_enable_n),
        .sync_out(rx_en_sync_n)
    );

    assign tx_bist = ~tx_en_sync_n;
    assign rx_bist = ~rx_en_sync_n;

    // generator steps only in the test state and resumes where it stopped, so the first loop after entry may be short
    sbs_lfsr u_tx_lfsr (
        .clk(clk),
        .rst_n(rst_n),
        .load(1'b0),
        .load_val(sbs_pkg::LFSR_SEED),
        .step(q.tx_st == sbs_pkg::SBS_TX_BIST),
        .state_q(tx_lfsr)
    );

    // checker holds the expected character; reloaded just past the start char
    sbs_lfsr u_rx_lfsr (
        .clk(clk),
        .rst_n(rst_n),
        .load(rx_load),
        .load_val(sbs_pkg::lfsr_next(sbs_pkg::LFSR_SEED)),
        .step(rx_step),
        .state_q(rx_lfsr)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // next state

    logic fifo_mode;
    logic tx_loop_ev;
    logic tx_obs;
    logic tx_act;
    logic rx_start;
    logic rx_mis;
    logic rx_last;
    logic rx_full_live;
    logic rx_full_obs;
    logic err_ev;
    logic rx_full_act;
    logic rx_accept;

    assign rx_load = (q.rx_st == sbs_pkg::SBS_RX_HUNT) && rx_start;
    assign rx_step = (q.rx_st == sbs_pkg::SBS_RX_SYNC) && rx_char_valid;

    always_comb begin
        d = q;
        fifo_mode = fifo_bypass_n;
        tx_act = 1'b0;
        rx_full_act = 1'b0;

        //////////////////////////////////////////// transmit path
        // loop start is the state that yields the loop-start data character
        tx_loop_ev = (q.tx_st == sbs_pkg::SBS_TX_BIST) && (tx_lfsr == sbs_pkg::LFSR_SEED);
        tx_obs = !q.tx_oe_n && (q.tx_empty_pin == sbs_pkg::flag_pin(1'b1, timing_model_select));
        unique case (q.tx_st)
            sbs_pkg::SBS_TX_NORMAL: begin
                // a pending pair must release its data character first
                d.tx_rd = tx_fifo_avail && (!tx_bist || tx_pair_pending);
                d.tx_char = tx_fifo_data;
                d.tx_valid = d.tx_rd;
                if (tx_bist && !tx_pair_pending) begin
                    d.tx_st = sbs_pkg::SBS_TX_BIST;
                    d.tx_empty_hold = 1'b0;
                end
                tx_act = tx_fifo_empty_in && !(tx_bist && !tx_pair_pending);
            end
            sbs_pkg::SBS_TX_BIST: begin
                // no fifo reads: unsent data waits in the fifo
                d.tx_rd = 1'b0;
                d.tx_char = tx_lfsr[sbs_pkg::CHAR_W-1:0];
                d.tx_valid = 1'b1;
                // new loop event wins over the observation clear
                d.tx_empty_hold = tx_loop_ev || (q.tx_empty_hold && !tx_obs);
                tx_act = fifo_mode ? d.tx_empty_hold : tx_loop_ev;
                if (!tx_bist) begin
                    d.tx_st = sbs_pkg::SBS_TX_NORMAL;
                    d.tx_empty_hold = 1'b0;
                end
            end
        endcase
        d.tx_empty_pin = sbs_pkg::flag_pin(tx_act, timing_model_select);
        // full flag keeps its fifo meaning so a reset can be monitored
        d.tx_full_pin = sbs_pkg::flag_pin(tx_fifo_full_in, timing_model_select);
        d.tx_oe_n = addr_match_n;

        //////////////////////////////////////////// receive path
        rx_start = rx_char_valid && (rx_char == sbs_pkg::LOOP_START_CHAR);
        rx_mis = rx_char != rx_lfsr[sbs_pkg::CHAR_W-1:0];
        rx_last = sbs_pkg::lfsr_next(rx_lfsr) == sbs_pkg::LFSR_SEED;
        err_ev = rx_step && rx_mis;
        rx_full_live = 1'b0;
        rx_full_obs = !q.rx_oe_n && (q.rx_full_pin == sbs_pkg::flag_pin(1'b1, timing_model_select));
        rx_accept = q.match || multicast_all_ones;
        unique case (q.rx_st)
            sbs_pkg::SBS_RX_NORMAL: begin
                if (rx_addr_cmd_valid && !multicast_all_ones) begin
                    d.match = rx_addr_hit;
                end
                if (!rx_atomic_pending) begin
                    d.drop = 1'b0;
                end
                if (rx_bist) begin
                    d.rx_st = sbs_pkg::SBS_RX_HUNT;
                    d.match = 1'b0;
                    d.drop = rx_atomic_pending;
                    d.rx_full_hold = fifo_mode;
                    d.err_hold = 1'b0;
                end
            end
            sbs_pkg::SBS_RX_HUNT: begin
                rx_full_live = 1'b1;
                if (rx_start) begin
                    d.rx_st = sbs_pkg::SBS_RX_SYNC;
                    d.err_hist = '0;
                end
            end
            sbs_pkg::SBS_RX_SYNC: begin
                rx_full_live = rx_step && rx_last;
                if (rx_step) begin
                    d.err_hist = {q.err_hist[sbs_pkg::ERR_WIN-2:0], rx_mis};
                end
                if (sbs_pkg::err_over_limit(d.err_hist)) begin
                    d.rx_st = sbs_pkg::SBS_RX_HUNT;
                end
            end
            default: begin
                d.rx_st = sbs_pkg::SBS_RX_HUNT;
            end
        endcase
        if (q.rx_st != sbs_pkg::SBS_RX_NORMAL) begin
            // events win over the read clear; bypass keeps nothing
            d.rx_full_hold = fifo_mode && (rx_full_live || (q.rx_full_hold && !rx_full_obs));
            d.err_hold = fifo_mode && (err_ev || (q.err_hold && q.bus_oe_n));
            rx_full_act = fifo_mode ? d.rx_full_hold : rx_full_live;
            d.err_pin = fifo_mode ? d.err_hold : err_ev;
            d.rx_empty_pin = sbs_pkg::flag_pin(1'b1, timing_model_select);
            d.rx_half_pin = sbs_pkg::flag_pin(1'b0, timing_model_select);
        end else begin
            rx_full_act = rx_fifo_full_in;
            d.err_pin = 1'b0;
            d.rx_empty_pin = sbs_pkg::flag_pin(rx_fifo_empty_in, timing_model_select);
            d.rx_half_pin = sbs_pkg::flag_pin(rx_fifo_half_in, timing_model_select);
        end
        if (!rx_bist) begin
            d.rx_st = sbs_pkg::SBS_RX_NORMAL;
            d.rx_full_hold = 1'b0;
            d.err_hold = 1'b0;
        end
        d.rx_full_pin = sbs_pkg::flag_pin(rx_full_act, timing_model_select);
        // writes gated by test state, address acceptance and dropped sequence
        d.rx_wr = rx_fifo_wr_req && !rx_bist && (q.rx_st == sbs_pkg::SBS_RX_NORMAL)
                  && rx_accept && !d.drop;
        d.rx_rd = rx_fifo_rd_req && !rx_bist && (q.rx_st == sbs_pkg::SBS_RX_NORMAL);
        d.rx_oe_n = addr_match_n;
        // error bit reaches the bus only while addressed and selected
        d.bus_oe_n = addr_match_n || rx_select_n;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // registers

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            q <= ST_RST;
        end else begin
            q <= d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // outputs

    assign tx_fifo_rd_en = q.tx_rd;
    assign tx_char = q.tx_char;
    assign tx_char_valid = q.tx_valid;
    assign tx_fifo_empty_flag = q.tx_empty_pin;
    assign tx_fifo_full_flag = q.tx_full_pin;
    assign tx_flags_oe_n = q.tx_oe_n;
    assign rx_fifo_wr_en = q.rx_wr;
    assign rx_fifo_rd_en = q.rx_rd;
    assign rx_fifo_empty_flag = q.rx_empty_pin;
    assign rx_fifo_half_flag = q.rx_half_pin;
    assign rx_fifo_full_flag = q.rx_full_pin;
    assign rx_flags_oe_n = q.rx_oe_n;
    assign rx_error_bit = q.err_pin;
    assign rx_bus_oe_n = q.bus_oe_n;

endmodule

// ==== tb/sbs_bist_top_assertions.sv ====
// sbs_bist_top_assertions: port-level timing checks for the link self-test block.
// assumes one clock domain; bound into every sbs_bist_top instance.
`timescale 1ns/10ps
module sbs_bist_top_assertions (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic tx_selftest_enable_n,
    input wire logic rx_selftest_enable_n,
    input wire logic addr_match_n,
    input wire logic rx_select_n,
    input wire logic timing_model_select,
    input wire logic fifo_bypass_n,
    input wire logic tx_fifo_full_in,
    input wire logic tx_fifo_rd_en,
    input wire logic tx_char_valid,
    input wire logic tx_fifo_empty_flag,
    input wire logic tx_fifo_full_flag,
    input wire logic tx_flags_oe_n,
    input wire logic rx_fifo_wr_en,
    input wire logic rx_fifo_rd_en,
    input wire logic rx_fifo_empty_flag,
    input wire logic rx_fifo_half_flag,
    input wire logic rx_fifo_full_flag,
    input wire logic rx_flags_oe_n,
    input wire logic rx_error_bit,
    input wire logic rx_bus_oe_n
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    ////////////////////////////////////////////////////////////////////////////////
    // first edge after reset still sees reset-time inputs, hence the past(rst_n) guard
    tx_oe_a: assert property ($past(rst_n) |-> tx_flags_oe_n == $past(addr_match_n))
        else $error("tx flag drivers not following address match");
    rx_oe_a: assert property ($past(rst_n) |-> rx_flags_oe_n == $past(addr_match_n))
        else $error("rx flag drivers not following address match");
    bus_oe_a: assert property ($past(rst_n) |-> rx_bus_oe_n == $past(addr_match_n | rx_select_n))
        else $error("rx bus drivers not following selection");
    tx_full_a: assert property ($past(rst_n) |-> tx_fifo_full_flag ==
        ($past(timing_model_select) ? $past(tx_fifo_full_in) : !$past(tx_fifo_full_in)))
        else $error("tx full flag wrong level");
    tx_noread_a: assert property (!tx_selftest_enable_n [*8] |-> !tx_fifo_rd_en)
        else $error("tx fifo read during self-test");
    tx_pattern_a: assert property (!tx_selftest_enable_n [*8] |-> tx_char_valid)
        else $error("tx pattern gap during self-test");
    rx_block_a: assert property (!rx_selftest_enable_n [*8] |-> !rx_fifo_wr_en && !rx_fifo_rd_en)
        else $error("rx fifo access during self-test");
    rx_forced_a: assert property (!rx_selftest_enable_n [*8] |->
        rx_fifo_empty_flag == $past(timing_model_select) && rx_fifo_half_flag != $past(timing_model_select))
        else $error("rx empty or half flag not forced empty");
    tx_pulse_a: assert property ((!fifo_bypass_n && timing_model_select && !tx_selftest_enable_n) [*8]
        ##0 $rose(tx_fifo_empty_flag) |=> !tx_fifo_empty_flag)
        else $error("bypass loop pulse longer than one clock");
    cover property ($rose(tx_fifo_empty_flag) && !fifo_bypass_n);
    cover property ($fell(rx_fifo_full_flag) && !rx_selftest_enable_n);
    cover property (!rx_bus_oe_n && rx_error_bit);
endmodule

bind sbs_bist_top sbs_bist_top_assertions u_sbs_bist_top_assertions (.clk, .rst_n, .tx_selftest_enable_n,
    .rx_selftest_enable_n, .addr_match_n, .rx_select_n, .timing_model_select, .fifo_bypass_n, .tx_fifo_full_in,
    .tx_fifo_rd_en, .tx_char_valid, .tx_fifo_empty_flag, .tx_fifo_full_flag, .tx_flags_oe_n, .rx_fifo_wr_en,
    .rx_fifo_rd_en, .rx_fifo_empty_flag, .rx_fifo_half_flag, .rx_fifo_full_flag, .rx_flags_oe_n,
    .rx_error_bit, .rx_bus_oe_n);

// ==== tb/sbs_link_model.sv ====
// sbs_link_model: serial link loopback from the transmit encoder side to the receive decoder side.
// assumes one character per clock; corrupt swaps in a fixed wrong character.
`timescale 1ns/10ps
module sbs_link_model (
    input wire logic clk,
    input wire logic [sbs_pkg::CHAR_W-1:0] tx_char,
    input wire logic tx_char_valid,
    input wire logic corrupt,
    output logic [sbs_pkg::CHAR_W-1:0] rx_char,
    output logic rx_char_valid
);
    initial begin
        rx_char = 8'h3c;
        rx_char_valid = 1'b0;
    end
    // 8'h55 never equals the loop-start character, so a corrupted stream cannot false-lock
    always @(posedge clk) begin
        rx_char_valid <= tx_char_valid;
        if (!tx_char_valid) begin
            rx_char <= ~rx_char;
        end else if (corrupt) begin
            rx_char <= 8'h55;
        end else begin
            rx_char <= tx_char;
        end
    end
endmodule

// ==== tb/test_sbs_bist_top.sv ====
// test_sbs_bist_top: self-checking bench for the link self-test block.
// assumes sbs_link_model loops transmitted characters back into the receiver.
`timescale 1ns/10ps
module test_sbs_bist_top;
    logic clk = 1'b0, rst_n = 1'b0, corrupt = 1'b0;
    logic tx_selftest_enable_n = 1'b1, rx_selftest_enable_n = 1'b1, addr_match_n = 1'b1, rx_select_n = 1'b1;
    logic timing_model_select = 1'b0, fifo_bypass_n = 1'b1, tx_fifo_avail = 1'b0, tx_pair_pending = 1'b0;
    logic [sbs_pkg::CHAR_W-1:0] tx_fifo_data = 8'ha5;
    logic tx_fifo_empty_in = 1'b0, tx_fifo_full_in = 1'b0, rx_atomic_pending = 1'b0, rx_addr_cmd_valid = 1'b0;
    logic rx_addr_hit = 1'b0, multicast_all_ones = 1'b0, rx_fifo_wr_req = 1'b0, rx_fifo_rd_req = 1'b0;
    logic rx_fifo_empty_in = 1'b0, rx_fifo_half_in = 1'b0, rx_fifo_full_in = 1'b0;
    logic [sbs_pkg::CHAR_W-1:0] rx_char, tx_char;
    logic rx_char_valid, tx_fifo_rd_en, tx_char_valid, tx_fifo_empty_flag, tx_fifo_full_flag, tx_flags_oe_n;
    logic rx_fifo_wr_en, rx_fifo_rd_en, rx_fifo_empty_flag, rx_fifo_half_flag, rx_fifo_full_flag;
    logic rx_flags_oe_n, rx_error_bit, rx_bus_oe_n, tx_zero, rx_full_on;
    int bad_count = 0, checks = 0, rd_seen = 0;
    ////////////////////////////////////////////////////////////////////////////////
    always #5 clk = ~clk;
    assign tx_zero = tx_char_valid && (tx_char == 8'h00);
    assign rx_full_on = !rx_fifo_full_flag;
    always @(posedge clk) begin
        if (tx_fifo_rd_en === 1'b1) begin
            rd_seen++;
        end
    end
    sbs_bist_top u_sbs_bist_top (.clk, .rst_n, .tx_selftest_enable_n, .rx_selftest_enable_n, .addr_match_n,
        .rx_select_n, .timing_model_select, .fifo_bypass_n, .tx_fifo_avail, .tx_fifo_data, .tx_pair_pending,
        .tx_fifo_empty_in, .tx_fifo_full_in, .rx_char, .rx_char_valid, .rx_atomic_pending, .rx_addr_cmd_valid,
        .rx_addr_hit, .multicast_all_ones, .rx_fifo_wr_req, .rx_fifo_rd_req, .rx_fifo_empty_in, .rx_fifo_half_in,
        .rx_fifo_full_in, .tx_fifo_rd_en, .tx_char, .tx_char_valid, .tx_fifo_empty_flag, .tx_fifo_full_flag,
        .tx_flags_oe_n, .rx_fifo_wr_en, .rx_fifo_rd_en, .rx_fifo_empty_flag, .rx_fifo_half_flag,
        .rx_fifo_full_flag, .rx_flags_oe_n, .rx_error_bit, .rx_bus_oe_n);
    sbs_link_model u_sbs_link_model (.clk, .tx_char, .tx_char_valid, .corrupt, .rx_char, .rx_char_valid);
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [9:0] exp, input logic [9:0] got);
        checks++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD %s expected %0h seen %0h", what, exp, got);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    // stops at the next rising level of sig; bounded so a dead flag cannot hang the run
    task automatic edge_wait(ref logic sig, output int n);
        n = 0;
        while (sig === 1'b1 && n < 1600) begin
            cyc(1);
            n++;
        end
        while (sig !== 1'b1 && n < 1600) begin
            cyc(1);
            n++;
        end
    endtask
    task automatic period(input string what, ref logic sig);
        int n;
        edge_wait(sig, n);
        edge_wait(sig, n);
        chk(what, 10'd511, n[9:0]);
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        cyc(2);
        chk("tx_flags_oe_n", 1, tx_flags_oe_n);
        chk("rx_error_bit", 0, rx_error_bit);
        @(posedge clk);
        tx_fifo_avail <= 1'b1;
        cyc(3);
        chk("tx_fifo_rd_en", 1, tx_fifo_rd_en);
        $display("t_reset done");
    endtask
    task automatic t_tx_fifo();
        int r0;
        @(posedge clk);
        tx_pair_pending <= 1'b1;
        tx_selftest_enable_n <= 1'b0;
        cyc(2);
        chk("tx_fifo_rd_en", 1, tx_fifo_rd_en);
        @(posedge clk);
        tx_pair_pending <= 1'b0;
        cyc(10);
        r0 = rd_seen;
        period("tx loop length", tx_zero);
        chk("tx reads in test", 0, 10'(rd_seen - r0));
        cyc(100);
        chk("tx_flags_oe_n", 1, tx_flags_oe_n);
        @(posedge clk);
        addr_match_n <= 1'b0;
        tx_fifo_full_in <= 1'b1;
        cyc(2);
        chk("held loop flag", 0, tx_fifo_empty_flag);
        chk("tx_fifo_full_flag", 0, tx_fifo_full_flag);
        cyc(4);
        chk("loop flag after read", 1, tx_fifo_empty_flag);
        @(posedge clk);
        tx_selftest_enable_n <= 1'b1;
        tx_fifo_full_in <= 1'b0;
        cyc(8);
        chk("tx_fifo_rd_en", 1, tx_fifo_rd_en);
        $display("t_tx_fifo done");
    endtask
    task automatic t_tx_bypass();
        @(posedge clk);
        fifo_bypass_n <= 1'b0;
        timing_model_select <= 1'b1;
        tx_selftest_enable_n <= 1'b0;
        cyc(10);
        period("bypass pulse spacing", tx_fifo_empty_flag);
        cyc(1);
        chk("bypass pulse width", 0, tx_fifo_empty_flag);
        $display("t_tx_bypass done");
    endtask
    task automatic t_rx();
        int n;
        @(posedge clk);
        fifo_bypass_n <= 1'b1;
        timing_model_select <= 1'b0;
        addr_match_n <= 1'b1;
        rx_select_n <= 1'b0;
        rx_fifo_wr_req <= 1'b1;
        rx_fifo_rd_req <= 1'b1;
        rx_fifo_half_in <= 1'b1;
        edge_wait(tx_zero, n);
        @(posedge clk);
        rx_selftest_enable_n <= 1'b0;
        cyc(8);
        chk("rx_fifo_wr_en", 0, rx_fifo_wr_en);
        chk("rx_fifo_rd_en", 0, rx_fifo_rd_en);
        chk("rx_fifo_empty_flag", 0, rx_fifo_empty_flag);
        chk("rx_fifo_half_flag", 1, rx_fifo_half_flag);
        @(posedge clk);
        addr_match_n <= 1'b0;
        cyc(2);
        chk("rx full on entry", 0, rx_fifo_full_flag);
        period("rx loop length", rx_full_on);
        chk("rx_error_bit clean", 0, rx_error_bit);
        @(posedge clk);
        corrupt <= 1'b1;
        edge_wait(rx_error_bit, n);
        chk("rx_error_bit", 1, rx_error_bit);
        cyc(60);
        chk("rx full after errors", 0, rx_fifo_full_flag);
        $display("t_rx done");
    endtask
    task automatic t_rx_exit();
        @(posedge clk);
        rx_selftest_enable_n <= 1'b1;
        corrupt <= 1'b0;
        cyc(8);
        chk("rx_fifo_empty_flag", 1, rx_fifo_empty_flag);
        chk("rx_fifo_rd_en", 1, rx_fifo_rd_en);
        chk("rx_fifo_wr_en unmatched", 0, rx_fifo_wr_en);
        @(posedge clk);
        rx_addr_cmd_valid <= 1'b1;
        @(posedge clk);
        rx_addr_cmd_valid <= 1'b0;
        cyc(3);
        chk("rx_fifo_wr_en miss", 0, rx_fifo_wr_en);
        @(posedge clk);
        rx_addr_cmd_valid <= 1'b1;
        rx_addr_hit <= 1'b1;
        @(posedge clk);
        rx_addr_cmd_valid <= 1'b0;
        cyc(3);
        chk("rx_fifo_wr_en hit", 1, rx_fifo_wr_en);
        @(posedge clk);
        multicast_all_ones <= 1'b1;
        rx_addr_hit <= 1'b0;
        rx_atomic_pending <= 1'b1;
        rx_selftest_enable_n <= 1'b0;
        cyc(10);
        @(posedge clk);
        rx_selftest_enable_n <= 1'b1;
        cyc(8);
        chk("rx_fifo_wr_en dropped seq", 0, rx_fifo_wr_en);
        @(posedge clk);
        rx_atomic_pending <= 1'b0;
        cyc(2);
        chk("rx_fifo_wr_en multicast", 1, rx_fifo_wr_en);
        $display("t_rx_exit done");
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        t_reset();
        t_tx_fifo();
        t_tx_bypass();
        t_rx();
        t_rx_exit();
        report_and_stop();
    end
    // whole run is under 6000 clocks; 30000 leaves room for slow lock
    initial begin
        #300000;
        bad_count++;
        report_and_stop();
    end
endmodule
